// File: hw/cexp_defs.svh
`ifndef CEXP_DEFS_SVH
`define CEXP_DEFS_SVH
// ------------------------------------------------------------
// register indices, byte address is index times four
// ------------------------------------------------------------
`define CEXP_IDX_DBGCTL 6'h17
`define CEXP_IDX_DEBUG_EXCEPTION_PC 6'h18
`define CEXP_IDX_EEPC 6'h1e
`define CEXP_IDX_DSAVE 6'h1f
`define CEXP_IDX_IBPA 6'h20
`define CEXP_IDX_DBPA 6'h21
`define CEXP_IDX_DBPV 6'h22
`define CEXP_IDX_IMSK 6'h23
// ------------------------------------------------------------
// debug control fields
// ------------------------------------------------------------
`define CEXP_DC_SST 0
`define CEXP_DC_BRK 1
`define CEXP_DC_IBP 2
`define CEXP_DC_DBP 3
`define CEXP_DC_DVB 4
`define CEXP_DC_LVB 5
`define CEXP_DC_CODE 8
`define CEXP_DC_DM 30
// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define CEXP_RST_WORD 32'h0000_0000
`define CEXP_RST_IMSK 8'h00
`define CEXP_RESP_OKAY 2'h0
`define CEXP_RESP_SLVERR 2'h2
`define CEXP_N_EXC 21
`endif

// File: hw/cexp_pkg.sv
`include "cexp_defs.svh"
package cexp_pkg;
	typedef enum logic [4:0] {
		EXC_RESET = 5'h00, EXC_DSS = 5'h01, EXC_DEBUG_INTERRUPT = 5'h02, EXC_NMI = 5'h03,
		EXC_INT = 5'h04, EXC_DIB = 5'h05, EXC_FADR = 5'h06, EXC_IBE = 5'h07,
		EXC_DBP = 5'h08, EXC_SYS = 5'h09, EXC_BP = 5'h0a, EXC_RI = 5'h0b,
		EXC_CPU = 5'h0c, EXC_CEU = 5'h0d, EXC_OV = 5'h0e, EXC_TR = 5'h0f,
		EXC_DDB = 5'h10, EXC_LADR = 5'h11, EXC_SADR = 5'h12, EXC_DBE = 5'h13,
		EXC_DEBUG_LOAD_VALUE_MATCH = 5'h14
	} cexp_exc_e;
	typedef enum logic [1:0] {MODE_RUN = 2'b01, MODE_DEBUG = 2'b10} cexp_mode_e;
	typedef struct packed {
		logic step_done;
		logic dbg_return;
		logic fetch_valid;
		logic [31:0] fetch_addr;
		logic fetch_prot;
		logic fetch_berr;
		logic dbg_break_op;
		logic syscall_op;
		logic break_op;
		logic undef_op;
		logic cop_op;
		logic [1:0] cop_num;
		logic [3:0] cop_en;
		logic ext_op;
		logic ext_en;
		logic arith_trap;
		logic arith_sub;
		logic [31:0] op_a;
		logic [31:0] op_b;
		logic trap_op;
		logic trap_true;
		logic mem_valid;
		logic mem_store;
		logic [1:0] mem_size;
		logic [31:0] mem_addr;
		logic mem_prot;
		logic mem_berr;
		logic [31:0] store_data;
		logic load_valid;
		logic [31:0] load_data;
		logic [31:0] exc_pc;
	} cexp_pipe_s;
	typedef struct packed {
		logic take;
		cexp_exc_e code;
		logic debug;
		logic kill_wb;
	} cexp_exc_s;
endpackage

// File: hw/cexp_prio.sv
`timescale 1ns/1ps
module cexp_prio #(
	parameter int N = 21,
	parameter int IW = 5
) (
	input wire logic [N-1:0] i_req,
	output logic o_any,
	output logic [IW-1:0] o_idx
);
	// ------------------------------------------------------------
	// lowest index wins
	// ------------------------------------------------------------
	always_comb begin
		o_any = 1'b0;
		o_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_req[i]) begin
				o_any = 1'b1;
				o_idx = IW'(i);
			end
		end
	end
endmodule // cexp_prio

// File: hw/cexp_top.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "cexp_defs.svh"
// Behaviour
// - fixed priority resolves simultaneous exceptions
// - master clear or power-on takes reset
// - single step raises exception after step
// - debug pin or break request bit
// - nmi edge ranks below debug interrupt
// - interrupt only when requested and unmasked
// - fetch address matching breakpoint raises break
// - misaligned or protected fetch faults
// - fetch bus error raises fault
// - debug break opcode raises breakpoint
// - system call below debug breakpoint
// - software break below system call
// - undefined opcode raises reserved fault
// - disabled coprocessor instruction raises fault
// - disabled extension instruction raises fault
// - signed overflow faults, writeback killed
// - trap only when condition true
// - data address or store value break
// - misaligned or protected load faults
// - misaligned or protected store faults
// - data bus error raises fault
// - load value match, lowest priority
module cexp_top (
	input wire logic I_SYS_CLK,
	input wire logic I_RST_B,
	input wire logic I_MASTER_CLEAR_PIN_B,
	input wire logic I_DBG_INT,
	input wire logic I_NMI,
	input wire logic [7:0] I_IRQ,
	input wire cexp_pkg::cexp_pipe_s I_PIPE,
	output cexp_pkg::cexp_exc_s O_EXC,
	output logic O_DEBUG_MODE,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [7:0] I_AXI_AWADDR,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	output logic [1:0] O_AXI_BRESP,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	input wire logic [7:0] I_AXI_ARADDR,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		cexp_pkg::cexp_mode_e mode;
		logic por_pend;
		logic sst;
		logic brk;
		logic ibp_en;
		logic dbp_en;
		logic dvb_en;
		logic lvb_en;
		logic [4:0] last_code;
		logic [31:0] debug_exception_pc;
		logic [31:0] eepc;
		logic [31:0] dsave;
		logic [31:0] ibp_addr;
		logic [31:0] dbp_addr;
		logic [31:0] dbp_val;
		logic [7:0] irq_mask;
		cexp_pkg::cexp_exc_s exc;
		logic [1:0] master_clear_pin_s;
		logic [1:0] debug_interrupt_s;
		logic [2:0] nmi_s;
		logic [7:0] irq_s1;
		logic [7:0] irq_s2;
		logic aw_ok;
		logic w_ok;
		logic [5:0] aw_idx;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cexp_top_s;

	cexp_top_s st_q;
	cexp_top_s st_d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [`CEXP_N_EXC-1:0] req;
	logic req_any;
	logic [4:0] req_idx;
	logic aw_rdy;
	logic w_rdy;
	logic ar_rdy;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic misal(input logic [31:0] a, input logic [1:0] sz);
		misal = (sz == 2'h1) ? a[0] : (sz == 2'h2) ? (a[1:0] != 2'h0) : 1'b0;
	endfunction

	function automatic logic ovf(input logic [31:0] a, input logic [31:0] b, input logic sub);
		logic [31:0] r;
		r = sub ? (a - b) : (a + b);
		ovf = sub ? ((a[31] != b[31]) && (r[31] != a[31]))
			: ((a[31] == b[31]) && (r[31] != a[31]));
	endfunction

	function automatic logic is_dbg(input cexp_pkg::cexp_exc_e c);
		is_dbg = (c == cexp_pkg::EXC_DSS) || (c == cexp_pkg::EXC_DEBUG_INTERRUPT)
			|| (c == cexp_pkg::EXC_DIB) || (c == cexp_pkg::EXC_DBP)
			|| (c == cexp_pkg::EXC_DDB) || (c == cexp_pkg::EXC_DEBUG_LOAD_VALUE_MATCH);
	endfunction

	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			o[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
		end
		mrg = o;
	endfunction

	function automatic logic [31:0] dbgctl(input cexp_top_s s);
		dbgctl = `CEXP_RST_WORD;
		dbgctl[`CEXP_DC_SST] = s.sst;
		dbgctl[`CEXP_DC_BRK] = s.brk;
		dbgctl[`CEXP_DC_IBP] = s.ibp_en;
		dbgctl[`CEXP_DC_DBP] = s.dbp_en;
		dbgctl[`CEXP_DC_DVB] = s.dvb_en;
		dbgctl[`CEXP_DC_LVB] = s.lvb_en;
		dbgctl[`CEXP_DC_CODE +: 5] = s.last_code;
		dbgctl[`CEXP_DC_DM] = (s.mode == cexp_pkg::MODE_DEBUG);
	endfunction

	// returns {hit, data}
	function automatic logic [32:0] rd(input cexp_top_s s, input logic [5:0] idx);
		case (idx)
			`CEXP_IDX_DBGCTL: rd = {1'b1, dbgctl(s)};
			`CEXP_IDX_DEBUG_EXCEPTION_PC: rd = {1'b1, s.debug_exception_pc};
			`CEXP_IDX_EEPC: rd = {1'b1, s.eepc};
			`CEXP_IDX_DSAVE: rd = {1'b1, s.dsave};
			`CEXP_IDX_IBPA: rd = {1'b1, s.ibp_addr};
			`CEXP_IDX_DBPA: rd = {1'b1, s.dbp_addr};
			`CEXP_IDX_DBPV: rd = {1'b1, s.dbp_val};
			`CEXP_IDX_IMSK: rd = {1'b1, 24'h00_0000, s.irq_mask};
			default: rd = {1'b0, `CEXP_RST_WORD};
		endcase
	endfunction

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ------------------------------------------------------------
	// exception requests, index order is priority order
	// ------------------------------------------------------------
	logic run;
	logic dmatch;
	assign run = (st_q.mode == cexp_pkg::MODE_RUN);
	assign dmatch = I_PIPE.mem_valid && (I_PIPE.mem_addr == st_q.dbp_addr);

	always_comb begin
		req = '0;
		req[cexp_pkg::EXC_RESET] = !st_q.master_clear_pin_s[1] || st_q.por_pend;
		req[cexp_pkg::EXC_DSS] = run && st_q.sst && I_PIPE.step_done;
		req[cexp_pkg::EXC_DEBUG_INTERRUPT] = run && (st_q.debug_interrupt_s[1] || st_q.brk);
		req[cexp_pkg::EXC_NMI] = st_q.nmi_s[1] && !st_q.nmi_s[2];
		req[cexp_pkg::EXC_INT] = |(st_q.irq_s2 & st_q.irq_mask);
		req[cexp_pkg::EXC_DIB] = run && st_q.ibp_en && I_PIPE.fetch_valid
			&& (I_PIPE.fetch_addr == st_q.ibp_addr);
		req[cexp_pkg::EXC_FADR] = I_PIPE.fetch_valid
			&& ((I_PIPE.fetch_addr[1:0] != 2'h0) || I_PIPE.fetch_prot);
		req[cexp_pkg::EXC_IBE] = I_PIPE.fetch_valid && I_PIPE.fetch_berr;
		req[cexp_pkg::EXC_DBP] = I_PIPE.dbg_break_op;
		req[cexp_pkg::EXC_SYS] = I_PIPE.syscall_op;
		req[cexp_pkg::EXC_BP] = I_PIPE.break_op;
		req[cexp_pkg::EXC_RI] = I_PIPE.undef_op;
		req[cexp_pkg::EXC_CPU] = I_PIPE.cop_op && !I_PIPE.cop_en[I_PIPE.cop_num];
		req[cexp_pkg::EXC_CEU] = I_PIPE.ext_op && !I_PIPE.ext_en;
		req[cexp_pkg::EXC_OV] = I_PIPE.arith_trap
			&& ovf(I_PIPE.op_a, I_PIPE.op_b, I_PIPE.arith_sub);
		req[cexp_pkg::EXC_TR] = I_PIPE.trap_op && I_PIPE.trap_true;
		req[cexp_pkg::EXC_DDB] = run && dmatch && (st_q.dbp_en || (st_q.dvb_en
			&& I_PIPE.mem_store && (I_PIPE.store_data == st_q.dbp_val)));
		req[cexp_pkg::EXC_LADR] = I_PIPE.mem_valid && !I_PIPE.mem_store
			&& (misal(I_PIPE.mem_addr, I_PIPE.mem_size) || I_PIPE.mem_prot);
		req[cexp_pkg::EXC_SADR] = I_PIPE.mem_valid && I_PIPE.mem_store
			&& (misal(I_PIPE.mem_addr, I_PIPE.mem_size) || I_PIPE.mem_prot);
		req[cexp_pkg::EXC_DBE] = I_PIPE.mem_valid && I_PIPE.mem_berr;
		req[cexp_pkg::EXC_DEBUG_LOAD_VALUE_MATCH] = run && st_q.lvb_en && I_PIPE.load_valid
			&& (I_PIPE.load_data == st_q.dbp_val);
	end

	// one winner per cycle, the rest are dropped for this instruction
	cexp_prio #(
		.N(`CEXP_N_EXC),
		.IW(5)
	) u_prio (
		.i_req(req),
		.o_any(req_any),
		.o_idx(req_idx)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign aw_rdy = !st_q.aw_ok && !st_q.bvalid;
	assign w_rdy = !st_q.w_ok && !st_q.bvalid;
	assign ar_rdy = !st_q.rvalid;

	always_comb begin
		cexp_pkg::cexp_exc_e code;
		logic [32:0] r;
		logic [31:0] wv;
		st_d = st_q;
		code = cexp_pkg::cexp_exc_e'(req_idx);
		r = rd(st_q, I_AXI_ARADDR[7:2]);
		wv = `CEXP_RST_WORD;
		st_d.master_clear_pin_s = {st_q.master_clear_pin_s[0], I_MASTER_CLEAR_PIN_B};
		st_d.debug_interrupt_s = {st_q.debug_interrupt_s[0], I_DBG_INT};
		st_d.nmi_s = {st_q.nmi_s[1:0], I_NMI};
		st_d.irq_s1 = I_IRQ;
		st_d.irq_s2 = st_q.irq_s1;
		st_d.exc.take = req_any;
		st_d.exc.code = code;
		st_d.exc.debug = req_any && is_dbg(code);
		st_d.exc.kill_wb = req_any;
		if (I_PIPE.dbg_return && !run) begin
			st_d.mode = cexp_pkg::MODE_RUN;
		end
		if (req_any) begin
			st_d.last_code = req_idx;
			if (is_dbg(code)) begin
				// a debug entry saves the return point
				st_d.debug_exception_pc = I_PIPE.exc_pc;
				st_d.mode = cexp_pkg::MODE_DEBUG;
			end
			if (code == cexp_pkg::EXC_DEBUG_INTERRUPT) begin
				st_d.brk = 1'b0;
			end
			if (code == cexp_pkg::EXC_RESET || code == cexp_pkg::EXC_NMI) begin
				st_d.eepc = I_PIPE.exc_pc;
			end
			if (code == cexp_pkg::EXC_RESET) begin
				st_d.por_pend = 1'b0;
				st_d.mode = cexp_pkg::MODE_RUN;
			end
		end
		// ------------------------------------------------------------
		// register bus; a software write lands after the hardware
		// update so a set of the break bit beats its clear
		// ------------------------------------------------------------
		if (I_AXI_AWVALID && aw_rdy) begin
			st_d.aw_ok = 1'b1;
			st_d.aw_idx = I_AXI_AWADDR[7:2];
		end
		if (I_AXI_WVALID && w_rdy) begin
			st_d.w_ok = 1'b1;
			st_d.wdata = I_AXI_WDATA;
			st_d.wstrb = I_AXI_WSTRB;
		end
		if (st_q.aw_ok && st_q.w_ok) begin
			st_d.aw_ok = 1'b0;
			st_d.w_ok = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = `CEXP_RESP_OKAY;
			case (st_q.aw_idx)
				`CEXP_IDX_DBGCTL: begin
					wv = mrg(dbgctl(st_q), st_q.wdata, st_q.wstrb);
					st_d.sst = wv[`CEXP_DC_SST];
					st_d.brk = (st_q.wstrb[0] && st_q.wdata[`CEXP_DC_BRK]) || st_d.brk;
					st_d.ibp_en = wv[`CEXP_DC_IBP];
					st_d.dbp_en = wv[`CEXP_DC_DBP];
					st_d.dvb_en = wv[`CEXP_DC_DVB];
					st_d.lvb_en = wv[`CEXP_DC_LVB];
				end
				`CEXP_IDX_DEBUG_EXCEPTION_PC: st_d.debug_exception_pc = mrg(st_q.debug_exception_pc, st_q.wdata, st_q.wstrb);
				`CEXP_IDX_EEPC: st_d.eepc = mrg(st_q.eepc, st_q.wdata, st_q.wstrb);
				`CEXP_IDX_DSAVE: st_d.dsave = mrg(st_q.dsave, st_q.wdata, st_q.wstrb);
				`CEXP_IDX_IBPA: st_d.ibp_addr = mrg(st_q.ibp_addr, st_q.wdata, st_q.wstrb);
				`CEXP_IDX_DBPA: st_d.dbp_addr = mrg(st_q.dbp_addr, st_q.wdata, st_q.wstrb);
				`CEXP_IDX_DBPV: st_d.dbp_val = mrg(st_q.dbp_val, st_q.wdata, st_q.wstrb);
				`CEXP_IDX_IMSK: begin
					if (st_q.wstrb[0]) begin
						st_d.irq_mask = st_q.wdata[7:0];
					end
				end
				default: st_d.bresp = `CEXP_RESP_SLVERR;
			endcase
		end
		if (st_q.bvalid && I_AXI_BREADY) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.rvalid && I_AXI_RREADY) begin
			st_d.rvalid = 1'b0;
		end
		if (I_AXI_ARVALID && ar_rdy) begin
			st_d.rvalid = 1'b1;
			st_d.rdata = r[31:0];
			st_d.rresp = r[32] ? `CEXP_RESP_OKAY : `CEXP_RESP_SLVERR;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.mode <= cexp_pkg::MODE_RUN;
			st_q.por_pend <= 1'b1;
			st_q.master_clear_pin_s <= 2'h3;
			st_q.irq_mask <= `CEXP_RST_IMSK;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign O_EXC = st_q.exc;
	assign O_DEBUG_MODE = (st_q.mode == cexp_pkg::MODE_DEBUG);
	assign O_AXI_AWREADY = aw_rdy;
	assign O_AXI_WREADY = w_rdy;
	assign O_AXI_BVALID = st_q.bvalid;
	assign O_AXI_BRESP = st_q.bresp;
	assign O_AXI_ARREADY = ar_rdy;
	assign O_AXI_RVALID = st_q.rvalid;
	assign O_AXI_RDATA = st_q.rdata;
	assign O_AXI_RRESP = st_q.rresp;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!rst_n);

	property p_rst_wins;
		rst_n && req[cexp_pkg::EXC_RESET] |=> O_EXC.take && O_EXC.code == cexp_pkg::EXC_RESET;
	endproperty
	a_rst_wins: assert property (p_rst_wins) else $error("reset lost");
	property p_step;
		run && st_q.sst && I_PIPE.step_done && !req[0]
		|=> O_EXC.code == cexp_pkg::EXC_DSS ##1 O_DEBUG_MODE;
	endproperty
	a_step: assert property (p_step) else $error("single step missed");
	property p_brk_clr;
		O_EXC.take && O_EXC.code == cexp_pkg::EXC_DEBUG_INTERRUPT && !$past(st_q.aw_ok && st_q.w_ok)
		|-> !st_q.brk;
	endproperty
	a_brk_clr: assert property (p_brk_clr) else $error("break request stuck");
	property p_nmi;
		req[cexp_pkg::EXC_NMI] && !(|req[2:0]) |=> O_EXC.code == cexp_pkg::EXC_NMI;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi order wrong");
	property p_int;
		O_EXC.take && O_EXC.code == cexp_pkg::EXC_INT |-> $past(|(st_q.irq_s2 & st_q.irq_mask));
	endproperty
	a_int: assert property (p_int) else $error("masked interrupt taken");
	property p_ovf;
		O_EXC.take && O_EXC.code == cexp_pkg::EXC_OV |-> O_EXC.kill_wb;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow wrote back");
	property p_trap;
		I_PIPE.trap_op && !I_PIPE.trap_true
		|=> !(O_EXC.take && O_EXC.code == cexp_pkg::EXC_TR);
	endproperty
	a_trap: assert property (p_trap) else $error("false trap taken");
	property p_top;
		O_EXC.take |-> ($past(req) & ~({`CEXP_N_EXC{1'b1}} << O_EXC.code)) == '0
			&& (|($past(req) & ({{(`CEXP_N_EXC-1){1'b0}}, 1'b1} << O_EXC.code)));
	endproperty
	a_top: assert property (p_top) else $error("not the highest exception");
	property p_debug_exception_pc;
		O_EXC.debug |-> st_q.debug_exception_pc == $past(I_PIPE.exc_pc) || $past(st_q.aw_ok);
	endproperty
	a_debug_exception_pc: assert property (p_debug_exception_pc) else $error("return pc not saved");
	c_reset: cover property (O_EXC.take && O_EXC.code == cexp_pkg::EXC_RESET);
	c_debug_interrupt: cover property (O_EXC.take && O_EXC.code == cexp_pkg::EXC_DEBUG_INTERRUPT);
	c_debug_load_value_match: cover property (O_EXC.take && O_EXC.code == cexp_pkg::EXC_DEBUG_LOAD_VALUE_MATCH);
	c_wr: cover property (st_q.bvalid && I_AXI_BREADY);
endmodule // cexp_top

// File: verif/cexp_pipe_model.sv
`timescale 1ns/1ps
// ----
// pipeline stand-in: turns a mask of wanted exception codes into pipe fields
// ----
module cexp_pipe_model #(
	parameter logic [31:0] BPA = 32'h0000_1000,
	parameter logic [31:0] BPV = 32'h5a5a_0f0f
) (
	input wire logic i_clk,
	input wire logic [20:0] i_mask,
	input wire logic i_benign,
	input wire logic [31:0] i_pc,
	input wire logic [31:0] i_rnd,
	input wire cexp_pkg::cexp_exc_s i_exc,
	output cexp_pkg::cexp_pipe_s o_pipe
);
	logic ret_q = 1'b0;
	logic bad;
	logic alt;
	logic fsel;
	logic msel;
	// handler returns at once so later steps are not masked by debug mode
	always_ff @(posedge i_clk) begin
		ret_q <= (i_exc.take === 1'b1) && (i_exc.debug === 1'b1);
	end
	// benign drives the same instructions with the fault condition false, for codes 6, 12 to 15, 17 and 18
	always_comb begin
		bad = !i_benign;
		alt = i_rnd[0];
		fsel = bad && i_mask[6];
		msel = bad && (i_mask[17] || i_mask[18]);
		o_pipe = '0;
		o_pipe.exc_pc = i_pc;
		o_pipe.dbg_return = ret_q;
		o_pipe.step_done = i_mask[1];
		o_pipe.fetch_valid = i_mask[5] || i_mask[6] || i_mask[7];
		o_pipe.fetch_addr = i_mask[5] ? BPA : {i_rnd[31:2], 1'b0, fsel && !alt};
		o_pipe.fetch_prot = fsel && alt;
		o_pipe.fetch_berr = i_mask[7];
		o_pipe.dbg_break_op = i_mask[8];
		o_pipe.syscall_op = i_mask[9];
		o_pipe.break_op = i_mask[10];
		o_pipe.undef_op = i_mask[11];
		o_pipe.cop_op = i_mask[12];
		o_pipe.cop_num = i_rnd[2:1];
		o_pipe.cop_en = i_benign ? 4'hf : 4'h0;
		o_pipe.ext_op = i_mask[13];
		o_pipe.ext_en = i_benign;
		o_pipe.arith_trap = i_mask[14];
		o_pipe.arith_sub = i_rnd[3];
		o_pipe.op_a = i_rnd[3] ? 32'h8000_0000 : 32'h7fff_ffff;
		o_pipe.op_b = {31'h0, bad};
		o_pipe.trap_op = i_mask[15];
		o_pipe.trap_true = bad;
		o_pipe.mem_valid = |i_mask[19:16];
		o_pipe.mem_store = i_mask[18];
		o_pipe.mem_size = i_rnd[4] ? 2'h1 : 2'h2;
		o_pipe.mem_addr = i_mask[16] ? BPA : {i_rnd[31:2], 1'b0, msel && !alt};
		o_pipe.mem_prot = msel && alt;
		o_pipe.mem_berr = i_mask[19];
		o_pipe.store_data = i_mask[16] ? BPV : i_rnd;
		o_pipe.load_valid = i_mask[20];
		o_pipe.load_data = BPV;
	end
endmodule // cexp_pipe_model

// File: verif/cexp_top_tb_top.sv
`timescale 1ns/1ps
`include "cexp_defs.svh"
module cexp_top_tb_top;
	localparam logic [31:0] BPA = 32'h0000_1000;
	localparam logic [31:0] BPV = 32'h5a5a_0f0f;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic master_clear_pin_b = 1'b1;
	logic debug_interrupt = 1'b0;
	logic nmi = 1'b0;
	logic [7:0] irq = 8'h00;
	logic [20:0] mask = '0;
	logic benign = 1'b0;
	logic [31:0] pc = '0, rnd = '0, wd = '0, rd_d, pc8, v;
	cexp_pkg::cexp_pipe_s pipe;
	cexp_pkg::cexp_exc_s exc;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic awr, wrdy, bv, arr, rv, dbg_mode;
	logic [7:0] awa = '0, ara = '0;
	logic [3:0] ws = 4'hf;
	logic [1:0] br, rr;
	logic [5:0] ex_note;
	logic [5:0] exq[$];
	logic [33:0] rdq[$];
	logic [5:0] idx [8] = '{`CEXP_IDX_DBGCTL, `CEXP_IDX_DEBUG_EXCEPTION_PC, `CEXP_IDX_EEPC, `CEXP_IDX_DSAVE,
		`CEXP_IDX_IBPA, `CEXP_IDX_DBPA, `CEXP_IDX_DBPV, `CEXP_IDX_IMSK};
	logic [4:0] dbg [4] = '{5'h01, 5'h05, 5'h10, 5'h14};
	int failures = 0, compares = 0, seed = 39864;
	initial begin
		forever #2 clk = ~clk;
	end
	cexp_top cexp_top_inst (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_MASTER_CLEAR_PIN_B(master_clear_pin_b), .I_DBG_INT(debug_interrupt),
		.I_NMI(nmi), .I_IRQ(irq), .I_PIPE(pipe), .O_EXC(exc), .O_DEBUG_MODE(dbg_mode),
		.I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa), .I_AXI_WVALID(wv),
		.O_AXI_WREADY(wrdy), .I_AXI_WDATA(wd), .I_AXI_WSTRB(ws), .O_AXI_BVALID(bv),
		.I_AXI_BREADY(bry), .O_AXI_BRESP(br), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
		.I_AXI_ARADDR(ara), .O_AXI_RVALID(rv), .I_AXI_RREADY(rry), .O_AXI_RDATA(rd_d),
		.O_AXI_RRESP(rr));
	cexp_pipe_model #(.BPA(BPA), .BPV(BPV)) cexp_pipe_model_inst (.i_clk(clk), .i_mask(mask),
		.i_benign(benign), .i_pc(pc), .i_rnd(rnd), .i_exc(exc), .o_pipe(pipe));
	// ----
	// helpers
	// ----
	function automatic logic [7:0] ad(input logic [5:0] i);
		return {i, 2'b00};
	endfunction
	task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic test_done;
		check(34'(exq.size() + rdq.size()), 34'h0, "results never seen");
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic want(input logic [4:0] k);
		exq.push_back({k inside {5'h01, 5'h02, 5'h05, 5'h08, 5'h10, 5'h14}, k});
	endtask
	// ----
	// bus master
	// ----
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		bry <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (awv && awr) begin
				aw_done = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wrdy) begin
				w_done = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk); while (bv !== 1'b1);
		check(34'(br), 34'(er), "write response");
		bry <= 1'b0;
		@(posedge clk);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		rdq.push_back({er, d});
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		rry <= 1'b0;
		@(posedge clk);
	endtask
	// ----
	// stimulus: one pipe cycle or one pin pulse, then quiet
	// ----
	task automatic step(input logic [20:0] m, input logic b);
		pc <= $random(seed);
		rnd <= $random(seed);
		mask <= m;
		benign <= b;
		@(posedge clk);
		mask <= '0;
		repeat (6) @(posedge clk);
	endtask
	task automatic pins(input logic m, input logic d, input logic n, input logic [7:0] q);
		master_clear_pin_b <= m;
		debug_interrupt <= d;
		nmi <= n;
		irq <= q;
		@(posedge clk);
		master_clear_pin_b <= 1'b1;
		debug_interrupt <= 1'b0;
		nmi <= 1'b0;
		irq <= 8'h00;
		repeat (10) @(posedge clk);
	endtask
	// ----
	// result watcher
	// ----
	always @(posedge clk) begin
		if (exc.take === 1'b1) begin
			check(34'(exq.size() > 0), 34'h1, "exception not expected");
			if (exq.size() > 0) begin
				ex_note = exq.pop_front();
				check(34'({exc.debug, exc.code}), 34'(ex_note), "exception");
				check(34'(dbg_mode), 34'(ex_note[5]), "debug mode");
			end
			check(34'(exc.kill_wb), 34'h1, "writeback kill");
		end
		if (rv === 1'b1 && rry === 1'b1 && rdq.size() > 0) begin
			check({rr, rd_d}, rdq.pop_front(), "read data");
		end
	end
	initial begin : watchdog
		repeat (20000) @(posedge clk);
		check(34'h0, 34'h1, "timeout");
		test_done();
	end
	initial begin : main
		int b;
		want(5'h00);
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (idx[i]) axr(ad(idx[i]), `CEXP_RST_WORD, `CEXP_RESP_OKAY);
		axr(8'h00, 32'h0, `CEXP_RESP_SLVERR);
		axw(8'h00, 32'h1234_5678, `CEXP_RESP_SLVERR);
		for (int i = 1; i < 4; i++) begin
			v = $random(seed);
			axw(ad(idx[i]), v, `CEXP_RESP_OKAY);
			axr(ad(idx[i]), v, `CEXP_RESP_OKAY);
		end
		// each step keeps codes k..19 except 16 and 18, so only the top one may be taken
		for (int k = 6; k < 20; k++) begin
			if (k != 16 && k != 18) begin
				want(5'(k));
				step(((21'h1 << 20) - (21'h1 << k)) & ~21'h05_0000, 1'b0);
				if (k == 8) pc8 = pc;
			end
		end
		want(cexp_pkg::EXC_SADR);
		step(21'h04_0000, 1'b0);
		axr(ad(`CEXP_IDX_DEBUG_EXCEPTION_PC), pc8, `CEXP_RESP_OKAY);
		step(21'h02_f040, 1'b1);
		step(21'h04_0000, 1'b1);
		b = {$random(seed)} % 8;
		axw(ad(`CEXP_IDX_IMSK), 32'(8'hff ^ (8'h01 << b)), `CEXP_RESP_OKAY);
		pins(1'b1, 1'b0, 1'b0, 8'h01 << b);
		want(cexp_pkg::EXC_INT);
		pins(1'b1, 1'b0, 1'b0, 8'hff);
		want(cexp_pkg::EXC_NMI);
		pins(1'b1, 1'b0, 1'b1, 8'hff);
		want(cexp_pkg::EXC_DEBUG_INTERRUPT);
		pins(1'b1, 1'b1, 1'b0, 8'h00);
		want(cexp_pkg::EXC_RESET);
		pins(1'b0, 1'b0, 1'b1, 8'h00);
		want(cexp_pkg::EXC_DEBUG_INTERRUPT);
		axw(ad(`CEXP_IDX_DBGCTL), 32'h0000_0002, `CEXP_RESP_OKAY);
		repeat (6) @(posedge clk);
		axr(ad(`CEXP_IDX_DBGCTL), 32'h0000_0200, `CEXP_RESP_OKAY);
		axw(ad(`CEXP_IDX_IBPA), BPA, `CEXP_RESP_OKAY);
		axw(ad(`CEXP_IDX_DBPA), BPA, `CEXP_RESP_OKAY);
		axw(ad(`CEXP_IDX_DBPV), BPV, `CEXP_RESP_OKAY);
		axw(ad(`CEXP_IDX_DBGCTL), 32'h0000_002d, `CEXP_RESP_OKAY);
		foreach (dbg[i]) begin
			want(dbg[i]);
			step(21'h1 << dbg[i], 1'b0);
		end
		// store value break alone: a load at the address must not trip it
		axw(ad(`CEXP_IDX_DBGCTL), 32'h0000_0010, `CEXP_RESP_OKAY);
		step(21'h01_0000, 1'b1);
		want(cexp_pkg::EXC_DDB);
		step(21'h05_0000, 1'b1);
		axw(ad(`CEXP_IDX_DBGCTL), 32'h0, `CEXP_RESP_OKAY);
		// second reset mid-run must give a fresh power-on exception
		want(cexp_pkg::EXC_RESET);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		axr(ad(`CEXP_IDX_DSAVE), `CEXP_RST_WORD, `CEXP_RESP_OKAY);
		repeat (5) @(posedge clk);
		test_done();
	end
endmodule // cexp_top_tb_top
